// *** logic/icd_core.sv ***
// Instruction decode and cycle timing for a 14-bit instruction core.
// Assumes fetch, file memory and ALU run on the same oscillator clock.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1: Instruction words are 14 bits with all operands inside, no extension words.
// RULE2: Each word is classed as byte, bit, or literal/control format.
// RULE3: Instructions outside the exceptions complete in exactly one instruction cycle.
// RULE4: Direct and accumulator-target subroutine calls take two cycles.
// RULE5: Subroutine return, literal return and interrupt exit take two cycles.
// RULE6: Jumps, branches, taken bit-test skips and taken count-skips take two cycles.
// RULE7: Indirect access with pointer in program memory adds one cycle.
// RULE8: One instruction cycle is four oscillator clocks.
// RULE9: File operands are read, modified, then stored, even for pure writes.
// RULE10: Destination bit 0 stores to accumulator, 1 to the file register.
// RULE11: File address is a 7-bit field, 0x00 to 0x7F in the bank.
// RULE12: Bit instructions carry a 3-bit position within the 8-bit register.
// RULE13: Indirect instructions carry a one-bit pointer number, zero or one.
// RULE14: Indirect moves carry a two-bit pre/post increment/decrement mode.
// RULE15: Don't-care instruction bits never change decoding or execution.
// RULE16: Skip instructions take the second cycle only when the skip happens.
// RULE17: Literals come from low word bits: eight for data, wider for targets.
module icd_core (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Fetch
	input wire logic [13:0] i_instr,
	input wire logic i_instr_valid,
	// Datapath returns
	input wire logic [7:0] i_file_rdata,
	input wire logic [7:0] i_alu_result,
	input wire logic [1:0] i_ptr_in_prog,
	// Decoded fields and strobes
	output icd_pkg::icd_fields_t o_fields,
	output logic [1:0] o_phase,
	output logic o_fetch,
	output logic o_file_rd,
	output logic [7:0] o_operand,
	output logic o_file_wr,
	output logic o_acc_wr,
	output logic [7:0] o_wr_data,
	output logic o_ptr_update,
	output logic o_flow_change,
	output logic o_skip,
	output logic o_stall,
	output logic o_instr_done
);
	import icd_pkg::*;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic icd_dec_t decode(input logic [13:0] w);
		icd_dec_t d;
		d = '0;
		d.f.file_addr = w[6:0]; // RULE11
		d.f.bit_pos = w[9:7]; // RULE12
		d.f.lit8 = w[7:0]; // RULE17
		d.f.target = w[10:0]; // RULE17
		d.f.ptr_mode = icd_ptr_mode_t'(w[1:0]); // RULE14
		// Only defined bits are compared, so don't-care bits never steer the result.
		if (w[13:12] == GRP_BYTE && w[13:7] != 7'h00) begin // RULE2 RULE15
			d.f.fmt = FMT_BYTE;
			d.f.dest_file = w[7]; // RULE10
			d.c.uses_file = 1'b1;
			d.c.wr_file = w[7];
			d.c.wr_acc = !w[7];
			d.c.skip_zero = (w[13:8] == OP_DEC_SKIP) || (w[13:8] == OP_INC_SKIP); // RULE6
		end else if (w[13:12] == GRP_BIT) begin // RULE2
			d.f.fmt = FMT_BIT;
			d.f.dest_file = 1'b1;
			d.c.uses_file = 1'b1;
			d.c.skip_bit = w[11];
			d.c.skip_set = (w[11:10] == BIT_SKIP_SET);
			d.c.wr_file = !w[11];
		end else begin
			d.f.fmt = FMT_LIT_CTRL; // RULE2
			if (w[13:4] == OP_IND_MOVE) begin
				d.c.uses_file = 1'b1;
				d.c.ptr_move = 1'b1;
				d.c.indirect = 1'b1;
				d.f.ptr_num = w[2]; // RULE13
				d.f.dest_file = w[3];
				d.c.wr_file = w[3];
				d.c.wr_acc = !w[3];
			end
			d.c.call = (w == OP_IND_CALL) || (w[13:11] == OP_CALL); // RULE4
			d.c.ret = (w == OP_RETURN) || (w == OP_INT_EXIT) || (w[13:8] == OP_EXIT_LIT); // RULE5
			d.c.flow = (w == OP_ACC_BRANCH) || (w[13:11] == OP_JUMP)
				|| (w[13:9] == OP_REL_BRANCH); // RULE6
			d.c.wr_acc = d.c.wr_acc || (w[13:12] == 2'h3 && w[13:9] != OP_REL_BRANCH);
		end
		if (d.f.fmt != FMT_LIT_CTRL) begin
			d.c.indirect = (w[6:0] == IND_PORT0) || (w[6:0] == IND_PORT1);
			d.f.ptr_num = w[0]; // RULE13
		end
		return d;
	endfunction

	// ----------------------------------------
	// Cycle sequencing
	// ----------------------------------------
	typedef enum logic {ST_FIRST, ST_EXTRA} icd_state_t;

	icd_state_t st, next_st;
	logic [1:0] q, next_q;
	logic [1:0] extra, next_extra;
	logic [13:0] ir, next_ir;
	icd_ctl_t ctl, next_ctl;
	icd_fields_t fields, next_fields;
	logic [7:0] operand, next_operand;
	logic [7:0] result, next_result;
	logic skip_hit, next_skip_hit;
	logic fetch, next_fetch;
	logic file_rd, next_file_rd;
	logic file_wr, next_file_wr;
	logic acc_wr, next_acc_wr;
	logic ptr_upd, next_ptr_upd;
	logic flow_chg, next_flow_chg;
	logic skip, next_skip;
	logic stall, next_stall;
	logic done, next_done;
	logic ind_hit;
	logic two_cycle;
	icd_dec_t dec;

	assign dec = decode(i_instr_valid ? i_instr : OP_NOP);
	assign ind_hit = ctl.indirect && i_ptr_in_prog[fields.ptr_num]; // RULE7
	assign two_cycle = ctl.call || ctl.ret || ctl.flow;

	always_comb begin
		next_st = st;
		next_q = q + 2'h1; // RULE8
		next_extra = extra;
		next_ir = ir;
		next_ctl = ctl;
		next_fields = fields;
		next_operand = operand;
		next_result = result;
		next_skip_hit = skip_hit;
		next_file_rd = 1'b0;
		next_file_wr = 1'b0;
		next_acc_wr = 1'b0;
		next_ptr_upd = 1'b0;
		next_flow_chg = 1'b0;
		next_skip = 1'b0;
		next_done = 1'b0;
		case (st)
			ST_FIRST: begin
				case (q)
					Q_FIRST: begin
						next_ir = i_instr_valid ? i_instr : OP_NOP; // RULE1
						next_fields = dec.f;
						next_ctl = dec.c;
						next_skip_hit = 1'b0;
						next_file_rd = dec.c.uses_file; // RULE9
					end
					Q_READ: begin
						next_operand = i_file_rdata; // RULE9
					end
					Q_MODIFY: begin
						next_result = i_alu_result;
						next_skip_hit = (ctl.skip_bit && (operand[fields.bit_pos] == ctl.skip_set))
							|| (ctl.skip_zero && (i_alu_result == 8'h00)); // RULE16
					end
					default: begin
						next_file_wr = ctl.wr_file; // RULE9 RULE10
						next_acc_wr = ctl.wr_acc; // RULE10
						next_ptr_upd = ctl.ptr_move; // RULE14
						next_flow_chg = two_cycle;
						next_skip = skip_hit; // RULE16
						next_extra = 2'({1'b0, two_cycle} + {1'b0, skip_hit} + {1'b0, ind_hit});
						if (two_cycle || skip_hit || ind_hit) begin // RULE4 RULE5 RULE6 RULE7
							next_st = ST_EXTRA;
						end else begin
							next_done = 1'b1; // RULE3
						end
					end
				endcase
			end
			ST_EXTRA: begin
				if (q == Q_LAST) begin
					next_extra = extra - 2'h1;
					if (extra == 2'h1) begin
						next_st = ST_FIRST;
						next_done = 1'b1;
					end
				end
			end
			default: begin
				next_st = ST_FIRST;
			end
		endcase
		next_fetch = (next_st == ST_FIRST) && (next_q == Q_FIRST);
		next_stall = (next_st == ST_EXTRA);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			st <= ST_FIRST;
			q <= Q_FIRST;
			extra <= 2'h0;
			ir <= OP_NOP;
			ctl <= '0;
			fields <= '0;
			operand <= 8'h00;
			result <= 8'h00;
			skip_hit <= 1'b0;
			fetch <= 1'b1;
			file_rd <= 1'b0;
			file_wr <= 1'b0;
			acc_wr <= 1'b0;
			ptr_upd <= 1'b0;
			flow_chg <= 1'b0;
			skip <= 1'b0;
			stall <= 1'b0;
			done <= 1'b0;
		end else begin
			st <= next_st;
			q <= next_q;
			extra <= next_extra;
			ir <= next_ir;
			ctl <= next_ctl;
			fields <= next_fields;
			operand <= next_operand;
			result <= next_result;
			skip_hit <= next_skip_hit;
			fetch <= next_fetch;
			file_rd <= next_file_rd;
			file_wr <= next_file_wr;
			acc_wr <= next_acc_wr;
			ptr_upd <= next_ptr_upd;
			flow_chg <= next_flow_chg;
			skip <= next_skip;
			stall <= next_stall;
			done <= next_done;
		end
	end

	assign o_fields = fields;
	assign o_phase = q;
	assign o_fetch = fetch;
	assign o_file_rd = file_rd;
	assign o_operand = operand;
	assign o_file_wr = file_wr;
	assign o_acc_wr = acc_wr;
	assign o_wr_data = result;
	assign o_ptr_update = ptr_upd;
	assign o_flow_change = flow_chg;
	assign o_skip = skip;
	assign o_stall = stall;
	assign o_instr_done = done;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	logic end_first;
	assign end_first = (st == ST_FIRST) && (q == Q_LAST);

	a_word_taken: assert property ((fetch && i_instr_valid) |=> ir == $past(i_instr)) // RULE1
		else $error("Instruction word not captured whole.");
	a_format_class: assert property ((st == ST_FIRST && q == Q_READ && ir[13:12] == GRP_BIT)
		|-> fields.fmt == FMT_BIT) // RULE2
		else $error("Bit-format word misclassified.");
	a_single_cycle: assert property ((end_first && !two_cycle && !skip_hit && !ind_hit)
		|=> done && !stall) // RULE3
		else $error("Plain instruction did not end in one cycle.");
	a_call_two: assert property ((end_first && ctl.call && !ind_hit)
		|=> stall [*4] ##1 (!stall && fetch)) // RULE4
		else $error("Call did not take two cycles.");
	a_return_two: assert property ((end_first && ctl.ret && !ind_hit)
		|=> (stall && flow_chg) ##4 done) // RULE5
		else $error("Return did not take two cycles.");
	a_flow_two: assert property ((end_first && ctl.flow && !ind_hit)
		|=> flow_chg ##0 stall ##1 !done [*3] ##1 done) // RULE6
		else $error("Flow change did not take two cycles.");
	a_indirect_extra: assert property ((end_first && ind_hit && !two_cycle && !skip_hit)
		|=> stall [*4] ##1 !stall) // RULE7
		else $error("Indirect program access lacks its extra cycle.");
	// The fetch flag already stands during reset, so the release edge must not start a count.
	a_cycle_length: assert property ((fetch && $past(i_rst_n)) |=> !fetch [*3] ##1 (fetch || stall)) // RULE8
		else $error("Instruction cycle is not four clocks.");
	a_read_before_write: assert property (file_wr |-> $past(file_rd, 3)) // RULE9
		else $error("File written without a prior read.");
	a_dest_route: assert property ((end_first && fields.fmt == FMT_BYTE)
		|=> (file_wr == fields.dest_file) && (acc_wr == !fields.dest_file)) // RULE10
		else $error("Result routed against destination bit.");
	a_skip_only_hit: assert property ((end_first && (ctl.skip_bit || ctl.skip_zero)
		&& !skip_hit && !ind_hit) |=> done && !skip) // RULE16
		else $error("Untaken skip spent an extra cycle.");
	a_literal_low: assert property ((st == ST_FIRST && q == Q_READ)
		|-> fields.lit8 == ir[7:0] && fields.file_addr == ir[6:0]) // RULE11 RULE17
		else $error("Literal or address field misplaced.");

	c_call: cover property (end_first && ctl.call);
	c_skip_hit: cover property (skip);
	c_indirect_prog: cover property (end_first && ind_hit);
	c_file_write: cover property (file_wr && ctl.indirect);

endmodule // icd_core

`default_nettype wire

// *** logic/icd_pkg.sv ***
// Shared constants and types of the instruction cycle decoder.
// Assumes one oscillator clock domain; no package state.
`default_nettype none

package icd_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned OSC_PER_CYCLE = 4;
	localparam logic [1:0] Q_FIRST = 2'h0;
	localparam logic [1:0] Q_READ = 2'h1;
	localparam logic [1:0] Q_MODIFY = 2'h2;
	localparam logic [1:0] Q_LAST = 2'(OSC_PER_CYCLE - 1);

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	localparam logic [13:0] OP_NOP = 14'h0000;
	localparam logic [13:0] OP_RETURN = 14'h0008;
	localparam logic [13:0] OP_INT_EXIT = 14'h0009;
	localparam logic [13:0] OP_IND_CALL = 14'h000A;
	localparam logic [13:0] OP_ACC_BRANCH = 14'h000B;
	localparam logic [9:0] OP_IND_MOVE = 10'h001;
	localparam logic [5:0] OP_DEC_SKIP = 6'h0B;
	localparam logic [5:0] OP_INC_SKIP = 6'h0F;
	localparam logic [5:0] OP_EXIT_LIT = 6'h34;
	localparam logic [4:0] OP_REL_BRANCH = 5'h19;
	localparam logic [2:0] OP_CALL = 3'h4;
	localparam logic [2:0] OP_JUMP = 3'h5;
	localparam logic [1:0] GRP_BYTE = 2'h0;
	localparam logic [1:0] GRP_BIT = 2'h1;
	localparam logic [1:0] BIT_SKIP_CLR = 2'h2;
	localparam logic [1:0] BIT_SKIP_SET = 2'h3;
	localparam logic [6:0] IND_PORT0 = 7'h00;
	localparam logic [6:0] IND_PORT1 = 7'h01;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {FMT_BYTE, FMT_BIT, FMT_LIT_CTRL} icd_fmt_t;
	typedef enum logic [1:0] {PM_PRE_INC, PM_PRE_DEC, PM_POST_INC, PM_POST_DEC} icd_ptr_mode_t;

	typedef struct packed {
		icd_fmt_t fmt;
		logic [6:0] file_addr;
		logic [2:0] bit_pos;
		logic dest_file;
		logic ptr_num;
		icd_ptr_mode_t ptr_mode;
		logic [7:0] lit8;
		logic [10:0] target;
	} icd_fields_t;

	typedef struct packed {
		logic uses_file;
		logic indirect;
		logic ptr_move;
		logic call;
		logic ret;
		logic flow;
		logic skip_bit;
		logic skip_set;
		logic skip_zero;
		logic wr_file;
		logic wr_acc;
	} icd_ctl_t;

	typedef struct packed {
		icd_fields_t f;
		icd_ctl_t c;
	} icd_dec_t;

endpackage

`default_nettype wire

// *** dv/tb_icd_core.sv ***
// Self-checking bench for the instruction cycle decoder core.
// Assumes icd_pkg is compiled first; the bench drives every core input itself.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; $display("BAD %s exp %h got %h", nm, ex, got); end end

module tb_icd_core;
	import icd_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic i_sys_clk, i_rst_n, i_instr_valid;
	logic [13:0] i_instr;
	logic [7:0] i_file_rdata, i_alu_result, o_operand, o_wr_data;
	logic [1:0] i_ptr_in_prog, o_phase;
	icd_fields_t o_fields;
	logic o_fetch, o_file_rd, o_file_wr, o_acc_wr, o_ptr_update;
	logic o_flow_change, o_skip, o_stall, o_instr_done;
	int errors = 0;
	int checks_done = 0;

	icd_core u_icd_core (
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_instr(i_instr), .i_instr_valid(i_instr_valid),
		.i_file_rdata(i_file_rdata), .i_alu_result(i_alu_result),
		.i_ptr_in_prog(i_ptr_in_prog), .o_fields(o_fields), .o_phase(o_phase),
		.o_fetch(o_fetch), .o_file_rd(o_file_rd), .o_operand(o_operand),
		.o_file_wr(o_file_wr), .o_acc_wr(o_acc_wr), .o_wr_data(o_wr_data),
		.o_ptr_update(o_ptr_update), .o_flow_change(o_flow_change),
		.o_skip(o_skip), .o_stall(o_stall), .o_instr_done(o_instr_done)
	);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Flags are {file_rd, file_wr, acc_wr, flow, skip, ptr_update}; care masks unknown ones.
	// The word is offered just after a fetch edge and held, so an idle NOP runs before it is taken.
	task automatic ex(input logic [13:0] w, input logic [7:0] rd, input logic [7:0] alu,
		input logic [1:0] pp, input int cyc, input logic [5:0] fl, input logic [5:0] care);
		icd_fmt_t fmt;
		int n;
		fmt = (w[13:12] == 2'h1) ? FMT_BIT :
			((w[13:12] == 2'h0 && w[13:7] != 7'h00) ? FMT_BYTE : FMT_LIT_CTRL);
		@(posedge i_sys_clk);
		i_instr <= w;
		i_instr_valid <= 1'b1;
		i_file_rdata <= rd;
		i_alu_result <= alu;
		i_ptr_in_prog <= pp;
		#1;
		n = 0;
		while (o_fetch !== 1'b1 && n < 40) begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		`CHK("fetch_wait", 1'b1, o_fetch)
		@(posedge i_sys_clk);
		i_instr_valid <= 1'b0;
		#1;
		`CHK("phase", 2'h1, o_phase)
		`CHK("fmt", fmt, o_fields.fmt)
		`CHK("file_rd", fl[5] & care[5], o_file_rd & care[5])
		if (fmt != FMT_LIT_CTRL) `CHK("addr", w[6:0], o_fields.file_addr)
		if (fmt == FMT_BIT) `CHK("bit_pos", w[9:7], o_fields.bit_pos)
		if (fmt == FMT_BYTE) `CHK("dest", w[7], o_fields.dest_file)
		if (w[13:12] == 2'h3) `CHK("lit8", w[7:0], o_fields.lit8)
		if (w[13:12] == 2'h2) `CHK("target", w[10:0], o_fields.target)
		if (w[13:4] == OP_IND_MOVE) `CHK("ptr_num", w[2], o_fields.ptr_num)
		if (w[13:4] == OP_IND_MOVE) `CHK("ptr_mode", w[1:0], o_fields.ptr_mode)
		@(posedge i_sys_clk);
		#1;
		if (fl[5]) `CHK("operand", rd, o_operand)
		repeat (2) @(posedge i_sys_clk);
		#1;
		`CHK("strobes", fl[4:0] & care[4:0], {o_file_wr, o_acc_wr, o_flow_change, o_skip,
			o_ptr_update} & care[4:0])
		if (fl[4] | fl[3]) `CHK("wr_data", alu, o_wr_data)
		n = 4;
		while (o_instr_done !== 1'b1 && n < 16) begin
			`CHK("stall", 1'b1, o_stall)
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		`CHK("clocks", 4 * cyc, n)
		`CHK("fetch", 1'b1, o_fetch)
	endtask

	// ----------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------
	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	// 25 instructions of at most 20 clocks each; 5000 clocks leaves a wide margin.
	initial begin
		#100000;
		errors++;
		tally_and_finish();
	end

	initial begin
		i_rst_n = 1'b0;
		i_instr = 14'h0000;
		i_instr_valid = 1'b0;
		i_file_rdata = 8'h00;
		i_alu_result = 8'h00;
		i_ptr_in_prog = 2'h0;
		repeat (12) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		#1;
		`CHK("rst_fetch", 1'b1, o_fetch)
		`CHK("rst_phase", 2'h0, o_phase)
		ex(14'h07FF, 8'h3C, 8'h55, 2'h0, 1, 6'b110000, 6'h3F);
		ex(14'h0720, 8'h3C, 8'h66, 2'h0, 1, 6'b101000, 6'h3F);
		ex(14'h0781, 8'h11, 8'h22, 2'h2, 2, 6'b110000, 6'h3F);
		ex(14'h0781, 8'h11, 8'h22, 2'h1, 1, 6'b110000, 6'h3F);
		ex(14'h1390, 8'h00, 8'h80, 2'h0, 1, 6'b110000, 6'h3F);
		ex(14'h19A2, 8'h08, 8'h00, 2'h0, 1, 6'b100000, 6'h3F);
		ex(14'h19A2, 8'hF7, 8'h00, 2'h0, 2, 6'b100010, 6'h3F);
		ex(14'h1C05, 8'h01, 8'h00, 2'h0, 2, 6'b100010, 6'h3F);
		ex(14'h1C00, 8'h01, 8'h00, 2'h1, 3, 6'b100010, 6'h3F);
		ex(14'h0BB0, 8'h01, 8'h00, 2'h0, 2, 6'b110010, 6'h3F);
		ex(14'h0F30, 8'h04, 8'h05, 2'h0, 1, 6'b101000, 6'h3F);
		ex(14'h27FF, 8'h00, 8'h00, 2'h0, 2, 6'b000100, 6'h3F);
		ex(14'h000A, 8'h00, 8'h00, 2'h0, 2, 6'b000100, 6'h3F);
		ex(14'h0008, 8'h00, 8'h00, 2'h0, 2, 6'b000100, 6'h3F);
		ex(14'h0009, 8'h00, 8'h00, 2'h0, 2, 6'b000100, 6'h3F);
		ex(14'h34A5, 8'h00, 8'hA5, 2'h0, 2, 6'b001100, 6'h3F);
		ex(14'h2923, 8'h00, 8'h00, 2'h0, 2, 6'b000100, 6'h3F);
		ex(14'h000B, 8'h00, 8'h00, 2'h0, 2, 6'b000100, 6'h3F);
		ex(14'h32FF, 8'h00, 8'h00, 2'h0, 2, 6'b000100, 6'h3F);
		ex(14'h3E3C, 8'h00, 8'h3C, 2'h0, 1, 6'b001000, 6'h3F);
		ex(14'h0000, 8'h00, 8'h00, 2'h0, 1, 6'b000000, 6'h3F);
		for (int m = 0; m < 4; m++) begin
			ex(14'h001C | 14'(m), 8'h00, 8'h77, 2'h2, 2, 6'b010001, 6'h1F);
		end
		tally_and_finish();
	end
endmodule // tb_icd_core

`default_nettype wire
